/* logic/rdc_pkg.sv */
// Shared constants, carriers and helper functions of the resolver tracker
package rdc_pkg;

    // Clock and sampling rates in Hz
    localparam int CLK_HZ     = 125_000_000;
    localparam int SAMPLE_HZ  = 160_000;
    localparam int CARRIER_HZ = 10_000;

    // Sample period in clock cycles; rounds down, so the rate runs slightly fast
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    // Samples per carrier period
    localparam int SPC        = SAMPLE_HZ / CARRIER_HZ;

    localparam logic [9:0] DIV_LAST   = 10'(SAMPLE_DIV - 1);
    localparam logic [9:0] DIV_ZERO   = 10'h000;
    localparam logic [9:0] DUTY_MID   = 10'(SAMPLE_DIV / 2);
    localparam logic signed [10:0] DUTY_GAIN = 11'sh003;
    localparam logic [3:0] PEAK_PHASE = 4'(SPC - 1);
    localparam logic [3:0] LAST_STEP  = 4'hF;
    localparam logic [3:0] SHIFT_MAX  = 4'hE;

    // Widths, FIFO depth and angle constants
    localparam int ADC_W   = 12;
    localparam int ANG_W   = 16;
    localparam int FIFO_DEPTH = 8;
    localparam logic [ANG_W-1:0] HALF_REV = 16'h8000;
    localparam logic [ANG_W-1:0] ZERO_REV = 16'h0000;

    // One converted sample pair with the carrier phase it was taken at
    typedef struct packed {
        logic [3:0]       phase;
        logic [ADC_W-1:0] sin;
        logic [ADC_W-1:0] cos;
    } rdc_sample_t;

    localparam int SAMPLE_W = $bits(rdc_sample_t);

    // Tracking configuration, frozen while tracking runs
    typedef struct packed {
        logic [ADC_W-1:0] off_sin;
        logic [ADC_W-1:0] off_cos;
        logic [15:0]      kp;
        logic [3:0]       f_shift;
        logic [3:0]       zi_shift;
        logic [31:0]      mag_ref;
        logic [31:0]      mag_tol;
        logic [15:0]      err_thr;
        logic [9:0]       trig_dly;
    } rdc_cfg_t;

    // Sine of carrier phase i (16 steps per cycle), scaled to 127
    function automatic logic signed [7:0] sin8(input logic [3:0] i);
        logic [2:0]        j;
        logic [2:0]        m;
        logic signed [7:0] v;
        j = i[2:0];
        m = (j > 3'h4) ? 3'(4'h8 - {1'b0, j}) : j;
        unique case (m)
            3'h0:    v = 8'sh00;
            3'h1:    v = 8'sh31;
            3'h2:    v = 8'sh5A;
            3'h3:    v = 8'sh75;
            default: v = 8'sh7F;
        endcase
        return i[3] ? -v : v;
    endfunction

    // PWM compare value for carrier phase p
    function automatic logic [9:0] duty_of(input logic [3:0] p);
        logic signed [10:0] d;
        d = $signed({1'b0, DUTY_MID}) + 11'(sin8(p)) * DUTY_GAIN;
        return d[9:0];
    endfunction

    // Arctangent of 2^-i in units of 1/65536 revolution
    function automatic logic [15:0] atan_step(input logic [3:0] i);
        logic [15:0] a;
        unique case (i)
            4'h0: a = 16'h2000;
            4'h1: a = 16'h12E4;
            4'h2: a = 16'h09FB;
            4'h3: a = 16'h0511;
            4'h4: a = 16'h028B;
            4'h5: a = 16'h0146;
            4'h6: a = 16'h00A3;
            4'h7: a = 16'h0051;
            4'h8: a = 16'h0029;
            4'h9: a = 16'h0014;
            4'hA: a = 16'h000A;
            4'hB: a = 16'h0005;
            4'hC: a = 16'h0003;
            4'hD: a = 16'h0001;
            4'hE: a = 16'h0001;
            4'hF: a = 16'h0000;
        endcase
        return a;
    endfunction

endpackage

/* logic/rdc_fifo.sv */
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module rdc_fifo #(
    parameter int W     = 28,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // Drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;
    logic          push;
    logic          pop;

    // Ready is registered so the filling side sees a clean level
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem[rd_reg];
    assign cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_reg] <= in_data_i;
        end
    end

    // Pointers, level and ready
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg     <= '0;
            rd_reg     <= '0;
            cnt_reg    <= '0;
            in_ready_o <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg    <= cnt_next;
            in_ready_o <= (cnt_next != (AW+1)'(DEPTH));
        end
    end
endmodule
`default_nettype wire

/* logic/rdc_tracker.sv */
// Resolver-to-digital tracker: carrier PWM, sampling, band-pass, tracking loop, checks
// What this block does
// - The resolver primary is excited with a fixed 10 kHz sine carrier.
// - The carrier leaves as a sine-weighted PWM pin that is filtered outside the block.
// - The dither return pin is driven low at all times.
// - Sine and cosine are sampled at 160 kHz, sixteen samples per carrier period.
// - A configured offset is subtracted from every sample before any processing.
// - The carrier value is updated on the same tick that paces sampling.
// - The converter trigger sits at a configured delay so samples hit the signal peaks.
// - Sine squared plus cosine squared is checked against a reference within a tolerance.
// - A loop angle error above a threshold raises a loss-of-tracking flag.
// - The integrator zero is always kept below the error filter pole.
// - Each channel passes a band-pass FIR centred on the carrier.
// - The loop error is the arctangent of sine over cosine minus the estimated angle.
// - The error is smoothed by a first-order low-pass before the controller.
// - The output angle is advanced by half a carrier period of the speed estimate.
`timescale 1ns/1ns
`default_nettype none
module rdc_tracker (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Control
    input  wire logic                          run_i,
    input  wire rdc_pkg::rdc_cfg_t             cfg_i,
    // Converter
    input  wire logic                          adc_valid_i,
    input  wire logic [rdc_pkg::ADC_W-1:0]     adc_sin_i,
    input  wire logic [rdc_pkg::ADC_W-1:0]     adc_cos_i,
    output logic                               adc_ready_o,
    output var logic                           adc_start_o,
    // Resolver drive pins
    output var logic                           pwm_o,
    output var logic                           dither_o,
    // Results
    output var logic [rdc_pkg::ANG_W-1:0]      angle_o,
    output var logic signed [31:0]             speed_o,
    output var logic                           angle_valid_o,
    output var logic                           sanity_fault_o,
    output var logic                           track_fault_o
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_FIR  = 6'h02,
        ST_PREP = 6'h04,
        ST_CORD = 6'h08,
        ST_ERR  = 6'h10,
        ST_PI   = 6'h20
    } rdc_state_t;

    rdc_pkg::rdc_cfg_t    cfg_reg;
    rdc_pkg::rdc_sample_t push_data;
    rdc_pkg::rdc_sample_t head;
    rdc_state_t           st_reg;
    logic [9:0]           div_reg;
    logic                 tick;
    logic [3:0]           phase_reg;
    logic [3:0]           trig_phase_reg;
    logic [9:0]           duty_reg;
    logic                 head_valid;
    logic                 pop;
    logic signed [12:0]   new_s;
    logic signed [12:0]   new_c;
    logic signed [12:0]   buf_s [16];
    logic signed [12:0]   buf_c [16];
    logic [3:0]           k_reg;
    logic signed [24:0]   acc_s_reg;
    logic signed [24:0]   acc_c_reg;
    logic signed [19:0]   cx_reg;
    logic signed [19:0]   cy_reg;
    logic [15:0]          cz_reg;
    logic signed [15:0]   ms;
    logic signed [15:0]   mc;
    logic [31:0]          mag;
    logic [31:0]          dev;
    logic signed [19:0]   x0;
    logic signed [19:0]   y0;
    logic [3:0]           f_eff;
    logic [3:0]           zi_eff;
    logic signed [15:0]   err;
    logic [16:0]          err_abs;
    logic signed [31:0]   filt_reg;
    logic signed [31:0]   integ_reg;
    logic signed [31:0]   integ_next;
    logic signed [31:0]   speed_next;
    logic signed [31:0]   half_spd;
    logic signed [47:0]   prod;
    logic [31:0]          ang_reg;
    logic [31:0]          ang_next;
    logic [31:0]          comp;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Configuration only follows the inputs while stopped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= '0;
        end else if (!run_i) begin
            cfg_reg <= cfg_i;
        end
    end

    // Filter pole capped below the top shift so a slower zero always exists
    assign f_eff  = (cfg_reg.f_shift > rdc_pkg::SHIFT_MAX) ? rdc_pkg::SHIFT_MAX : cfg_reg.f_shift;
    assign zi_eff = (cfg_reg.zi_shift > f_eff) ? cfg_reg.zi_shift : f_eff + 4'h1;
    AST_ZERO_BELOW_POLE: assert property (zi_eff > f_eff)
        else $error("integrator zero not below filter pole");

    // Sample-rate divider; one tick per sample period
    assign tick = (div_reg == rdc_pkg::DIV_LAST);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg <= rdc_pkg::DIV_ZERO;
        end else begin
            div_reg <= tick ? rdc_pkg::DIV_ZERO : div_reg + 10'h001;
        end
    end
    AST_TICK_PERIOD: assert property (tick |-> ##[781:781] tick)
        else $error("sample tick period wrong");

    // Carrier phase and PWM compare step together with the sample tick
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= 4'h0;
            duty_reg  <= rdc_pkg::DUTY_MID;
        end else if (tick) begin
            phase_reg <= phase_reg + 4'h1;
            duty_reg  <= rdc_pkg::duty_of(phase_reg + 4'h1);
        end
    end
    AST_CARRIER_SYNC: assert property (tick |=> duty_reg == rdc_pkg::duty_of(phase_reg)
                                       && phase_reg == $past(phase_reg) + 4'h1)
        else $error("carrier not updated with sample tick");

    // Drive pins: sine-weighted PWM, dither return held at ground
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_o    <= 1'b0;
            dither_o <= 1'b0;
        end else begin
            pwm_o    <= (div_reg < duty_reg);
            dither_o <= 1'b0;
        end
    end
    AST_DITHER_LOW: assert property (!dither_o)
        else $error("dither return not low");

    // Converter trigger at the configured point of each sample period
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            adc_start_o    <= 1'b0;
            trig_phase_reg <= 4'h0;
        end else begin
            adc_start_o <= run_i && (div_reg == cfg_reg.trig_dly);
            if (div_reg == cfg_reg.trig_dly) begin
                trig_phase_reg <= phase_reg;
            end
        end
    end
    AST_TRIG_PLACE: assert property (adc_start_o |-> $past(div_reg) == cfg_reg.trig_dly)
        else $error("converter trigger misplaced");

    // Results queue up so a slow drain stalls the converter, not the loop
    assign push_data = '{phase: trig_phase_reg, sin: adc_sin_i, cos: adc_cos_i};
    rdc_fifo #(
        .W     (rdc_pkg::SAMPLE_W),
        .DEPTH (rdc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (adc_valid_i),
        .in_data_i   (push_data),
        .in_ready_o  (adc_ready_o),
        .out_valid_o (head_valid),
        .out_data_o  (head),
        .out_ready_i (pop)
    );

    // Offset removal on the way into the filter history
    assign pop   = (st_reg == ST_IDLE) && head_valid && run_i;
    assign new_s = $signed({1'b0, head.sin}) - $signed({1'b0, cfg_reg.off_sin});
    assign new_c = $signed({1'b0, head.cos}) - $signed({1'b0, cfg_reg.off_cos});
    always_ff @(posedge clk_i) begin
        if (pop) begin
            for (int i = 0; i < 15; i++) begin
                buf_s[i] <= buf_s[i+1];
                buf_c[i] <= buf_c[i+1];
            end
            buf_s[15] <= new_s;
            buf_c[15] <= new_c;
        end
    end
    AST_OFFSET: assert property (pop |=> buf_s[15] == $past(new_s) && buf_c[15] == $past(new_c))
        else $error("offset not removed");

    // Sequencer; one pass per carrier period, started by the peak sample
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= ST_IDLE;
        end else begin
            unique case (st_reg)
                ST_IDLE: if (pop && head.phase == rdc_pkg::PEAK_PHASE) st_reg <= ST_FIR;
                ST_FIR:  if (k_reg == rdc_pkg::LAST_STEP) st_reg <= ST_PREP;
                ST_PREP: st_reg <= ST_CORD;
                ST_CORD: if (k_reg == rdc_pkg::LAST_STEP) st_reg <= ST_ERR;
                ST_ERR:  st_reg <= ST_PI;
                ST_PI:   st_reg <= ST_IDLE;
            endcase
        end
    end

    // Pass lengths checked by entry and exit points; no long repetition to unroll
    sequence s_fir_pass;
        (st_reg == ST_FIR) ##16 (st_reg == ST_PREP);
    endsequence
    sequence s_cordic_pass;
        (st_reg == ST_CORD) ##16 (st_reg == ST_ERR);
    endsequence
    AST_FIR_LEN: assert property (pop && head.phase == rdc_pkg::PEAK_PHASE |=> s_fir_pass)
        else $error("band-pass pass length wrong");
    AST_ATAN_LEN: assert property (st_reg == ST_PREP |=> s_cordic_pass ##1 st_reg == ST_PI)
        else $error("arctangent pass length wrong");

    // Carrier-matched band-pass FIR, then vectoring arctangent
    assign ms  = acc_s_reg[24:9];
    assign mc  = acc_c_reg[24:9];
    assign mag = 32'(ms * ms) + 32'(mc * mc);
    assign dev = (mag >= cfg_reg.mag_ref) ? mag - cfg_reg.mag_ref : cfg_reg.mag_ref - mag;
    assign x0  = 20'(acc_c_reg[24:8]);
    assign y0  = 20'(acc_s_reg[24:8]);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            k_reg     <= 4'h0;
            acc_s_reg <= '0;
            acc_c_reg <= '0;
            cx_reg    <= '0;
            cy_reg    <= '0;
            cz_reg    <= rdc_pkg::ZERO_REV;
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    k_reg     <= 4'h0;
                    acc_s_reg <= '0;
                    acc_c_reg <= '0;
                end
                ST_FIR: begin
                    acc_s_reg <= acc_s_reg + 25'(buf_s[k_reg] * rdc_pkg::sin8(k_reg));
                    acc_c_reg <= acc_c_reg + 25'(buf_c[k_reg] * rdc_pkg::sin8(k_reg));
                    k_reg     <= k_reg + 4'h1;
                end
                ST_PREP: begin
                    // Fold the left half plane so the iterations converge
                    cx_reg <= x0[19] ? -x0 : x0;
                    cy_reg <= x0[19] ? -y0 : y0;
                    cz_reg <= x0[19] ? rdc_pkg::HALF_REV : rdc_pkg::ZERO_REV;
                    k_reg  <= 4'h0;
                end
                ST_CORD: begin
                    if (!cy_reg[19]) begin
                        cx_reg <= cx_reg + (cy_reg >>> k_reg);
                        cy_reg <= cy_reg - (cx_reg >>> k_reg);
                        cz_reg <= cz_reg + rdc_pkg::atan_step(k_reg);
                    end else begin
                        cx_reg <= cx_reg - (cy_reg >>> k_reg);
                        cy_reg <= cy_reg + (cx_reg >>> k_reg);
                        cz_reg <= cz_reg - rdc_pkg::atan_step(k_reg);
                    end
                    k_reg <= k_reg + 4'h1;
                end
                default: k_reg <= 4'h0;
            endcase
        end
    end

    // Amplitude sanity check on the filtered pair
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sanity_fault_o <= 1'b0;
        end else if (st_reg == ST_PREP) begin
            sanity_fault_o <= (dev > cfg_reg.mag_tol);
        end
    end
    AST_SANITY: assert property (st_reg == ST_PREP |=> sanity_fault_o == ($past(dev) > cfg_reg.mag_tol))
        else $error("sanity flag does not follow amplitude");

    // Loop error, its low-pass and the tracking check
    assign err     = $signed(cz_reg - ang_reg[31:16]);
    assign err_abs = err[15] ? 17'(-err) : 17'(err);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            filt_reg      <= '0;
            track_fault_o <= 1'b0;
        end else if (!run_i) begin
            filt_reg <= '0;
        end else if (st_reg == ST_ERR) begin
            filt_reg      <= filt_reg + (({err, 16'h0000} - filt_reg) >>> f_eff);
            track_fault_o <= (err_abs > {1'b0, cfg_reg.err_thr});
        end
    end
    AST_TRACK: assert property (st_reg == ST_ERR && err_abs > {1'b0, cfg_reg.err_thr} && run_i
                                |=> track_fault_o ##1 track_fault_o)
        else $error("loss of tracking not flagged");

    // PI controller, angle integrator and group delay compensation
    assign integ_next = integ_reg + (filt_reg >>> zi_eff);
    assign prod       = 48'(filt_reg + integ_next) * $signed({1'b0, cfg_reg.kp});
    assign speed_next = prod[47:16];
    assign ang_next   = ang_reg + speed_next;
    assign half_spd   = speed_next >>> 1;
    assign comp       = ang_next + half_spd;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            integ_reg     <= '0;
            ang_reg       <= '0;
            speed_o       <= '0;
            angle_o       <= rdc_pkg::ZERO_REV;
            angle_valid_o <= 1'b0;
        end else if (!run_i) begin
            integ_reg     <= '0;
            ang_reg       <= '0;
            speed_o       <= '0;
            angle_valid_o <= 1'b0;
        end else begin
            angle_valid_o <= (st_reg == ST_PI);
            if (st_reg == ST_PI) begin
                integ_reg <= integ_next;
                ang_reg   <= ang_next;
                speed_o   <= speed_next;
                angle_o   <= comp[31:16];
            end
        end
    end
    AST_ANGLE_OUT: assert property (angle_valid_o |->
                                    angle_o == 16'(32'(ang_reg + 32'(speed_o >>> 1)) >> 16))
        else $error("output angle not advanced by half carrier of speed");
    AST_VALID_PULSE: assert property (angle_valid_o |=> !angle_valid_o)
        else $error("angle valid longer than one cycle");
endmodule
`default_nettype wire

/* dv/rdc_resolver_model.sv */
// Behavioural resolver, front end and converter answering each trigger
`timescale 1ns/1ns
`default_nettype none
module rdc_resolver_model #(
    parameter int LAT = 20,
    parameter int DIV = 781
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Converter handshake
    input  wire logic              start_i,
    input  wire logic              ready_i,
    output logic                   valid_o,
    // Shaft position as sine and cosine scale factors
    input  wire logic signed [7:0] sa_i,
    input  wire logic signed [7:0] ca_i,
    // Converted samples
    output logic [11:0]            sin_o,
    output logic [11:0]            cos_o
);
    localparam int CAR [16] = '{0, 38, 71, 92, 100, 92, 71, 38,
                                0, -38, -71, -92, -100, -92, -71, -38};
    int          cnt;
    int          dv;
    logic [3:0]  ph;
    logic [3:0]  lp;
    logic [11:0] ls;
    logic [11:0] lc;

    // Own view of the carrier phase, stepping once per sample period
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dv <= 0;
            ph <= 4'h0;
        end else begin
            dv <= (dv == DIV - 1) ? 0 : dv + 1;
            if (dv == DIV - 1) ph <= ph + 4'h1;
        end
    end

    // Conversion takes LAT cycles; the result is held until room is seen
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            lp <= 4'h0;
            valid_o <= 1'b0;
            ls <= 12'h800;
            lc <= 12'h800;
        end else begin
            if (valid_o && ready_i) valid_o <= 1'b0;
            if (start_i) begin
                cnt <= LAT;
                lp <= ph;
            end else if (cnt > 1) cnt <= cnt - 1;
            else if (cnt == 1) begin
                cnt <= 0;
                valid_o <= 1'b1;
                ls <= 12'(2048 + sa_i * CAR[lp]);
                lc <= 12'(2048 + ca_i * CAR[lp]);
            end
        end
    end

    // Idle data lines show the inverse so stale values never pass as fresh
    always_comb begin
        sin_o = valid_o ? ls : ~ls;
        cos_o = valid_o ? lc : ~lc;
    end
endmodule
`default_nettype wire

/* dv/rdc_tracker_tb.sv */
// Self-checking bench of the resolver tracker
`timescale 1ns/1ns
`default_nettype none
module rdc_tracker_tb;
    typedef struct packed {
        logic signed [7:0] amp;
        logic [15:0]       thr;
        logic [31:0]       tol;
        logic              san;
        logic              trk;
    } rdc_row_t;
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  run_i = 1'b0;
    rdc_pkg::rdc_cfg_t     cfg_i = '0;
    logic                  adc_valid_i;
    logic [11:0]           adc_sin_i;
    logic [11:0]           adc_cos_i;
    logic                  adc_ready_o;
    logic                  adc_start_o;
    logic                  pwm_o;
    logic                  dither_o;
    logic [15:0]           angle_o;
    logic signed [31:0]    speed_o;
    logic                  angle_valid_o;
    logic                  sanity_fault_o;
    logic                  track_fault_o;
    logic signed [7:0]     amp = 8'sh04;
    logic                  pwm_q = 1'b0;
    int                    err_count = 0;
    int                    total_checks = 0;
    int                    cyc = 0;
    int                    t_st = 0;
    int                    t_pwm = 0;
    int                    t_av = 0;
    rdc_row_t              rows [3];

    always #4 clk_i = ~clk_i;

    rdc_tracker rdc_tracker_inst (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_i), .cfg_i(cfg_i),
        .adc_valid_i(adc_valid_i), .adc_sin_i(adc_sin_i), .adc_cos_i(adc_cos_i),
        .adc_ready_o(adc_ready_o), .adc_start_o(adc_start_o), .pwm_o(pwm_o),
        .dither_o(dither_o), .angle_o(angle_o), .speed_o(speed_o),
        .angle_valid_o(angle_valid_o), .sanity_fault_o(sanity_fault_o),
        .track_fault_o(track_fault_o));
    rdc_resolver_model rdc_resolver_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .start_i(adc_start_o), .ready_i(adc_ready_o), .valid_o(adc_valid_i),
        .sa_i(amp), .ca_i(amp), .sin_o(adc_sin_i), .cos_o(adc_cos_i));

    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Bounded wait for the next result pulse
    task wait_valid();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (angle_valid_o !== 1'b1 && n < 14000);
        if (n >= 14000) check(32'h0, 32'h1);
    endtask

    // Spacing monitor; sampled after the drive delay so inputs have landed
    always @(posedge clk_i) begin
        #2;
        cyc++;
        if (!run_i) begin
            t_st = 0;
            t_av = 0;
        end
        if (pwm_o === 1'b1 && pwm_q === 1'b0) begin
            if (t_pwm != 0) check(cyc - t_pwm, 32'h30D);
            t_pwm = cyc;
        end
        pwm_q = pwm_o;
        if (adc_start_o === 1'b1) begin
            if (t_st != 0) check(cyc - t_st, 32'h30D);
            if (t_pwm != 0) check(cyc - t_pwm, 32'h0C3);
            t_st = cyc;
        end
        if (angle_valid_o === 1'b1) begin
            if (t_av != 0) check(cyc - t_av, 32'h30D0);
            check(32'(angle_o), 32'h0);
            check(speed_o, 32'h0);
            check(32'(dither_o), 32'h0);
            t_av = cyc;
        end
    end

    // Hang guard, reckoned from three rows of up to two carrier periods each
    initial begin
        #(8 * 95000);
        err_count++;
        end_of_test();
    end

    // Reset, then one row per fault setting
    initial begin
        rows[0] = '{8'sh04, 16'hFFFF, 32'hFFFFFFFF, 1'b0, 1'b0};
        rows[1] = '{8'sh04, 16'h0010, 32'h00000000, 1'b1, 1'b1};
        rows[2] = '{8'sh00, 16'hFFFF, 32'h00000000, 1'b0, 1'b0};
        cfg_i.off_sin = 12'h800;
        cfg_i.off_cos = 12'h800;
        cfg_i.f_shift = 4'h2;
        cfg_i.zi_shift = 4'h4;
        cfg_i.trig_dly = 10'h0C3;
        repeat (6) @(posedge clk_i);
        #1;
        check(32'({adc_ready_o, adc_start_o, pwm_o, angle_valid_o}), 32'h0);
        check(32'({sanity_fault_o, track_fault_o, dither_o}), 32'h0);
        rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check(32'(adc_ready_o), 32'h1);
        foreach (rows[i]) begin
            run_i = 1'b0;
            cfg_i.err_thr = rows[i].thr;
            cfg_i.mag_tol = rows[i].tol;
            amp = rows[i].amp;
            repeat (2) @(posedge clk_i);
            #1;
            run_i = 1'b1;
            wait_valid();
            wait_valid();
            check(32'(sanity_fault_o), 32'(rows[i].san));
            check(32'(track_fault_o), 32'(rows[i].trk));
        end
        end_of_test();
    end
endmodule
`default_nettype wire
